// file: design/pmic_lamp_and_converter_control.v
// Lamp and converter configuration bank of the power manager.
// Assumes the serial interface engine presents byte writes and reads on the
// register port, on the same clock; straps and sleep pin are asynchronous.
`include "pmic_defs.vh"

module pmic_lamp_and_converter_control
#(
    parameter TIME_BASE_CYCLES = `TIME_BASE_CYCLES
)
(
    // Clock and reset
    input wire clk,
    input wire rst,
    // Register port from the serial interface
    input wire [7:0] reg_addr,
    input wire reg_wr,
    input wire [7:0] reg_wdata,
    input wire reg_rd,
    output reg [7:0] reg_rdata,
    output reg reg_rvalid,
    // Strap and sleep pins
    input wire io_rail_strap_pin,
    input wire processor_rail_strap_pin,
    input wire sleep_request_pin,
    // Charger inputs
    input wire wall_input_valid,
    input wire usb_input_valid,
    input wire charger_lamp_request,
    // Charger path selection
    output reg charge_from_wall,
    output reg charge_from_usb,
    // Status lamp open-drain pin
    input wire status_lamp_pin_in,
    output wire status_lamp_pin_out,
    output reg status_lamp_pin_oe,
    // Aux lamp open-drain pin
    input wire aux_lamp_pin_in,
    output wire aux_lamp_pin_out,
    output reg aux_lamp_pin_oe,
    // I/O rail converter
    output reg forced_fixed_freq,
    output reg [1:0] undervoltage_threshold,
    output reg low_power_mode,
    output reg wait_mode,
    output reg io_rail_enable,
    output reg io_rail_discharge,
    output reg [1:0] io_rail_code,
    // Processor rail converter
    output reg processor_rail_enable,
    output reg processor_rail_discharge,
    output reg [2:0] processor_rail_code,
    output reg motor_driver_enable
);

// ****************************************
// Registers
// ****************************************
reg [1:0] charger_config_reg;
reg [7:0] status_lamp_ontime_reg;
reg [7:0] status_lamp_period_reg;
reg [7:0] aux_lamp_ontime_reg;
reg [7:0] aux_lamp_period_reg;
reg [7:0] io_converter_config_reg;
reg [7:0] processor_converter_config_reg;
reg [2:0] strap_count_reg;
reg strap_done_reg;

wire io_strap_level;
wire proc_strap_level;
wire sleep_level;
wire strap_load;

// ****************************************
// Pin synchronisers
// ****************************************
pin_sync io_strap_sync
(
    .clk(clk),
    .rst(rst),
    .pin(io_rail_strap_pin),
    .level(io_strap_level)
);

pin_sync proc_strap_sync
(
    .clk(clk),
    .rst(rst),
    .pin(processor_rail_strap_pin),
    .level(proc_strap_level)
);

pin_sync sleep_sync
(
    .clk(clk),
    .rst(rst),
    .pin(sleep_request_pin),
    .level(sleep_level)
);

// Straps are taken once the synchronisers have settled after release
assign strap_load = !strap_done_reg && (strap_count_reg == `STRAP_LOAD_CYCLES);

always @(posedge clk or posedge rst)
begin
    if (rst)
    begin
        strap_count_reg <= 3'h0;
        strap_done_reg <= 1'b0;
    end
    else if (!strap_done_reg)
    begin
        if (strap_load)
        begin
            strap_done_reg <= 1'b1;
        end
        else
        begin
            strap_count_reg <= strap_count_reg + 3'h1;
        end
    end
end

// ****************************************
// Register writes
// ****************************************
function sel;
    input [7:0] addr;
    input [7:0] target;
    begin
        sel = (addr == target);
    end
endfunction

always @(posedge clk or posedge rst)
begin
    if (rst)
    begin
        charger_config_reg <= `RST_CHARGER_CONFIG;
        status_lamp_ontime_reg <= `RST_LAMP;
        status_lamp_period_reg <= `RST_LAMP;
        aux_lamp_ontime_reg <= `RST_LAMP;
        aux_lamp_period_reg <= `RST_LAMP;
        io_converter_config_reg <= `RST_IO_CONVERTER_CONFIG;
        processor_converter_config_reg <= `RST_PROCESSOR_CONVERTER_CONFIG;
    end
    else
    begin
        if (reg_wr && sel(reg_addr, `ADDR_CHARGER_CONFIG))
        begin
            charger_config_reg <= reg_wdata[1:0];
        end
        if (reg_wr && sel(reg_addr, `ADDR_STATUS_LAMP_ONTIME))
        begin
            status_lamp_ontime_reg <= reg_wdata;
        end
        if (reg_wr && sel(reg_addr, `ADDR_STATUS_LAMP_PERIOD))
        begin
            status_lamp_period_reg <= reg_wdata;
        end
        if (reg_wr && sel(reg_addr, `ADDR_AUX_LAMP_ONTIME))
        begin
            aux_lamp_ontime_reg <= reg_wdata;
        end
        if (reg_wr && sel(reg_addr, `ADDR_AUX_LAMP_PERIOD))
        begin
            aux_lamp_period_reg <= reg_wdata;
        end
        // A write in the strap cycle wins over the strap value
        if (reg_wr && sel(reg_addr, `ADDR_IO_CONVERTER_CONFIG))
        begin
            io_converter_config_reg <= reg_wdata;
        end
        else if (strap_load)
        begin
            io_converter_config_reg[`IO_RAIL_LO] <= io_strap_level;
        end
        if (reg_wr && sel(reg_addr, `ADDR_PROCESSOR_CONVERTER_CONFIG))
        begin
            processor_converter_config_reg <= reg_wdata;
        end
        else if (strap_load)
        begin
            processor_converter_config_reg[`PROC_RAIL_STRAP_BIT] <= proc_strap_level;
        end
    end
end

// ****************************************
// Register reads
// ****************************************
reg [7:0] read_next;

always @*
begin
    read_next = 8'h00;
    case (reg_addr)
        `ADDR_CHARGER_CONFIG: read_next = {6'h00, charger_config_reg};
        `ADDR_STATUS_LAMP_ONTIME: read_next = status_lamp_ontime_reg;
        `ADDR_STATUS_LAMP_PERIOD: read_next = status_lamp_period_reg;
        `ADDR_AUX_LAMP_ONTIME: read_next = aux_lamp_ontime_reg;
        `ADDR_AUX_LAMP_PERIOD: read_next = aux_lamp_period_reg;
        `ADDR_IO_CONVERTER_CONFIG: read_next = io_converter_config_reg;
        `ADDR_PROCESSOR_CONVERTER_CONFIG: read_next = processor_converter_config_reg;
        default: read_next = 8'h00;
    endcase
end

always @(posedge clk or posedge rst)
begin
    if (rst)
    begin
        reg_rdata <= 8'h00;
        reg_rvalid <= 1'b0;
    end
    else
    begin
        reg_rvalid <= reg_rd;
        if (reg_rd)
        begin
            reg_rdata <= read_next;
        end
    end
end

// ****************************************
// 10 ms time base
// ****************************************
reg [31:0] base_count_reg;
reg tick_reg;

always @(posedge clk or posedge rst)
begin
    if (rst)
    begin
        base_count_reg <= 32'h00000000;
        tick_reg <= 1'b0;
    end
    else if (base_count_reg >= TIME_BASE_CYCLES - 1)
    begin
        base_count_reg <= 32'h00000000;
        tick_reg <= 1'b1;
    end
    else
    begin
        base_count_reg <= base_count_reg + 32'h00000001;
        tick_reg <= 1'b0;
    end
end

// ****************************************
// Lamps
// ****************************************
wire [1:0] status_lamp_mode;
wire [1:0] aux_lamp_mode;
wire status_blink_on;
wire aux_blink_on;

assign status_lamp_mode = {status_lamp_ontime_reg[`LAMP_SEL_BIT], status_lamp_period_reg[`LAMP_SEL_BIT]};
assign aux_lamp_mode = {aux_lamp_ontime_reg[`LAMP_SEL_BIT], aux_lamp_period_reg[`LAMP_SEL_BIT]};
assign status_lamp_pin_out = 1'b0;
assign aux_lamp_pin_out = 1'b0;

lamp_blinker status_blinker
(
    .clk(clk),
    .rst(rst),
    .run(status_lamp_mode == `LAMP_MODE_BLINK),
    .tick(tick_reg),
    .ontime_field(status_lamp_ontime_reg[6:0]),
    .period_field(status_lamp_period_reg[6:0]),
    .lamp_on(status_blink_on)
);

lamp_blinker aux_blinker
(
    .clk(clk),
    .rst(rst),
    .run(aux_lamp_mode == `LAMP_MODE_BLINK),
    .tick(tick_reg),
    .ontime_field(aux_lamp_ontime_reg[6:0]),
    .period_field(aux_lamp_period_reg[6:0]),
    .lamp_on(aux_blink_on)
);

always @(posedge clk or posedge rst)
begin
    if (rst)
    begin
        status_lamp_pin_oe <= 1'b0;
        aux_lamp_pin_oe <= 1'b0;
    end
    else
    begin
        case (status_lamp_mode)
            `LAMP_MODE_CHARGER: status_lamp_pin_oe <= charger_lamp_request;
            `LAMP_MODE_BLINK: status_lamp_pin_oe <= status_blink_on;
            `LAMP_MODE_ON: status_lamp_pin_oe <= 1'b1;
            default: status_lamp_pin_oe <= 1'b0;
        endcase
        case (aux_lamp_mode)
            `LAMP_MODE_BLINK: aux_lamp_pin_oe <= aux_blink_on;
            `LAMP_MODE_ON: aux_lamp_pin_oe <= 1'b1;
            default: aux_lamp_pin_oe <= 1'b0;
        endcase
    end
end

// ****************************************
// Charger path and converter control
// ****************************************
wire sleep_active;
wire lp_next;
wire wait_next;
wire proc_off_next;

assign sleep_active = sleep_level && io_converter_config_reg[`IO_SLEEP_GATE_BIT];
assign lp_next = sleep_active && io_converter_config_reg[`IO_LOW_POWER_SEL_BIT];
assign wait_next = sleep_active && !io_converter_config_reg[`IO_LOW_POWER_SEL_BIT];
assign proc_off_next = wait_next || (lp_next && processor_converter_config_reg[`PROC_SHUTDOWN_BIT]);

always @(posedge clk or posedge rst)
begin
    if (rst)
    begin
        charge_from_wall <= 1'b0;
        charge_from_usb <= 1'b0;
        forced_fixed_freq <= 1'b0;
        undervoltage_threshold <= 2'h1;
        low_power_mode <= 1'b0;
        wait_mode <= 1'b0;
        io_rail_enable <= 1'b1;
        io_rail_discharge <= 1'b0;
        io_rail_code <= 2'h2;
        processor_rail_enable <= 1'b1;
        processor_rail_discharge <= 1'b0;
        processor_rail_code <= 3'h6;
        motor_driver_enable <= 1'b0;
    end
    else
    begin
        charge_from_wall <= charger_config_reg[`CHG_ENABLE_BIT] && wall_input_valid;
        charge_from_usb <= charger_config_reg[`CHG_ENABLE_BIT] && charger_config_reg[`CHG_USB_PERMIT_BIT]
            && usb_input_valid && !wall_input_valid;
        forced_fixed_freq <= io_converter_config_reg[`IO_FIXED_FREQ_BIT];
        undervoltage_threshold <= io_converter_config_reg[`IO_UV_HI:`IO_UV_LO];
        low_power_mode <= lp_next;
        wait_mode <= wait_next;
        io_rail_enable <= !wait_next;
        io_rail_discharge <= wait_next && io_converter_config_reg[`IO_DISCHARGE_BIT];
        io_rail_code <= io_converter_config_reg[`IO_RAIL_HI:`IO_RAIL_LO];
        processor_rail_enable <= !proc_off_next;
        processor_rail_discharge <= proc_off_next && processor_converter_config_reg[`PROC_DISCHARGE_BIT];
        if (lp_next)
        begin
            processor_rail_code <= {1'b0, processor_converter_config_reg[`PROC_SLEEP_HI:`PROC_SLEEP_LO]};
        end
        else
        begin
            processor_rail_code <= processor_converter_config_reg[`PROC_RAIL_HI:`PROC_RAIL_LO];
        end
        motor_driver_enable <= processor_converter_config_reg[`PROC_MOTOR_BIT];
    end
end

endmodule

// file: common/pmic_defs.vh
// Register offsets, field positions, reset values and timing counts of the
// lamp and converter control bank. Assumes a 200 MHz clock.
`ifndef PMIC_DEFS_VH
`define PMIC_DEFS_VH

// ****************************************
// Register offsets
// ****************************************
`define ADDR_CHARGER_CONFIG 8'h07
`define ADDR_STATUS_LAMP_ONTIME 8'h08
`define ADDR_STATUS_LAMP_PERIOD 8'h09
`define ADDR_AUX_LAMP_ONTIME 8'h0A
`define ADDR_AUX_LAMP_PERIOD 8'h0B
`define ADDR_IO_CONVERTER_CONFIG 8'h0C
`define ADDR_PROCESSOR_CONVERTER_CONFIG 8'h0D

// ****************************************
// Reset values
// ****************************************
`define RST_CHARGER_CONFIG 2'h3
`define RST_LAMP 8'h00
`define RST_IO_CONVERTER_CONFIG 8'h32
`define RST_PROCESSOR_CONVERTER_CONFIG 8'h60

// ****************************************
// Field positions
// ****************************************
`define CHG_ENABLE_BIT 0
`define CHG_USB_PERMIT_BIT 1
`define LAMP_SEL_BIT 7
`define IO_FIXED_FREQ_BIT 7
`define IO_UV_HI 6
`define IO_UV_LO 5
`define IO_LOW_POWER_SEL_BIT 4
`define IO_SLEEP_GATE_BIT 3
`define IO_DISCHARGE_BIT 2
`define IO_RAIL_HI 1
`define IO_RAIL_LO 0
`define PROC_SHUTDOWN_BIT 7
`define PROC_RAIL_HI 6
`define PROC_RAIL_LO 4
`define PROC_RAIL_STRAP_BIT 4
`define PROC_SLEEP_HI 3
`define PROC_SLEEP_LO 2
`define PROC_MOTOR_BIT 1
`define PROC_DISCHARGE_BIT 0

// ****************************************
// Lamp modes (select high, select low)
// ****************************************
`define LAMP_MODE_CHARGER 2'h0
`define LAMP_MODE_BLINK 2'h1
`define LAMP_MODE_OFF 2'h2
`define LAMP_MODE_ON 2'h3

// ****************************************
// Timing
// ****************************************
`define CLK_FREQ_HZ 200000000
`define TIME_BASE_MS 10
`define TIME_BASE_CYCLES ((`CLK_FREQ_HZ / 1000) * `TIME_BASE_MS)
`define ONTIME_STEP_MS 10
`define PERIOD_STEP_MS 100
`define ONTIME_STEP_TICKS (`ONTIME_STEP_MS / `TIME_BASE_MS)
`define PERIOD_STEP_TICKS (`PERIOD_STEP_MS / `TIME_BASE_MS)
`define STRAP_LOAD_CYCLES 3'h4

`endif

// file: design/pin_sync.v
// Three-stage synchroniser for a pin input.
// Assumes the pin is asynchronous to clk; output changes when stages 2 and 3 agree.
module pin_sync
(
    // Clock and reset
    input wire clk,
    input wire rst,
    // Pin and synchronised level
    input wire pin,
    output reg level
);

reg s1_reg;
reg s2_reg;
reg s3_reg;

always @(posedge clk or posedge rst)
begin
    if (rst)
    begin
        s1_reg <= 1'b0;
        s2_reg <= 1'b0;
        s3_reg <= 1'b0;
        level <= 1'b0;
    end
    else
    begin
        s1_reg <= pin;
        s2_reg <= s1_reg;
        s3_reg <= s2_reg;
        if (s2_reg == s3_reg)
        begin
            level <= s3_reg;
        end
    end
end

endmodule

// file: design/lamp_blinker.v
// Blink generator for one open-drain lamp.
// Assumes a one-cycle 10 ms tick from a shared divider.
`include "pmic_defs.vh"

module lamp_blinker
(
    // Clock and reset
    input wire clk,
    input wire rst,
    // Control
    input wire run,
    input wire tick,
    input wire [6:0] ontime_field,
    input wire [6:0] period_field,
    // Lamp request
    output reg lamp_on
);

reg [10:0] count_reg;
wire [10:0] on_ticks;
wire [10:0] period_ticks;
wire [31:0] on_ticks_full;
wire [31:0] period_ticks_full;

// Longest period is 1280 ticks, so eleven bits always hold the product
assign on_ticks_full = ({25'h0000000, ontime_field} + 32'h00000001) * `ONTIME_STEP_TICKS;
assign period_ticks_full = ({25'h0000000, period_field} + 32'h00000001) * `PERIOD_STEP_TICKS;
assign on_ticks = on_ticks_full[10:0];
assign period_ticks = period_ticks_full[10:0];

always @(posedge clk or posedge rst)
begin
    if (rst)
    begin
        count_reg <= 11'h000;
        lamp_on <= 1'b0;
    end
    else if (!run)
    begin
        count_reg <= 11'h000;
        lamp_on <= 1'b0;
    end
    else
    begin
        // On from each period start for the on-time
        lamp_on <= (count_reg < on_ticks);
        if (tick)
        begin
            if (count_reg >= period_ticks - 11'h001)
            begin
                count_reg <= 11'h000;
            end
            else
            begin
                count_reg <= count_reg + 11'h001;
            end
        end
    end
end

endmodule

// file: tb/pmic_lamp_and_converter_control_props.sv
// Port checker for the lamp and converter configuration bank.
// Assumes one clock domain with an asynchronous active-high reset; bound from the bench.
module pmic_lamp_and_converter_control_props
(
    // Clock and reset
    input wire clk,
    input wire rst,
    // Register port and pins
    input wire reg_rd,
    input wire reg_rvalid,
    input wire sleep_request_pin,
    input wire wall_input_valid,
    input wire usb_input_valid,
    // Observed outputs
    input wire charge_from_wall,
    input wire charge_from_usb,
    input wire status_lamp_pin_out,
    input wire aux_lamp_pin_out,
    input wire low_power_mode,
    input wire wait_mode,
    input wire io_rail_enable,
    input wire io_rail_discharge,
    input wire processor_rail_enable,
    input wire processor_rail_discharge,
    input wire [2:0] processor_rail_code
);
    timeunit 1ns;
    timeprecision 100ps;

    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);

    // ****************************************
    // Sequences
    // ****************************************
    sequence s_sleep_idle;
        !sleep_request_pin [*8];
    endsequence
    sequence s_normal;
        (!low_power_mode && !wait_mode) [*3];
    endsequence

    // ****************************************
    // Assertions
    // ****************************************
    a_read_answer: assert property (reg_rd |=> reg_rvalid)
        else $error("read strobe not answered");
    a_read_quiet: assert property (!reg_rd |=> !reg_rvalid)
        else $error("read valid without strobe");
    a_wall_valid: assert property (charge_from_wall |-> $past(wall_input_valid))
        else $error("wall path without wall input");
    a_wall_first: assert property (charge_from_usb |-> !charge_from_wall && !$past(wall_input_valid))
        else $error("usb path while wall input valid");
    a_usb_valid: assert property (charge_from_usb |-> $past(usb_input_valid))
        else $error("usb path without usb input");
    a_open_drain: assert property (status_lamp_pin_out == 1'b0 && aux_lamp_pin_out == 1'b0)
        else $error("lamp pin driven high");
    a_mode_excl: assert property (!(low_power_mode && wait_mode))
        else $error("low-power and wait together");
    a_sleep_idle: assert property (s_sleep_idle |-> !low_power_mode && !wait_mode)
        else $error("sleep mode without request");
    a_rails_normal: assert property (s_normal |-> io_rail_enable && processor_rail_enable
        && !io_rail_discharge && !processor_rail_discharge)
        else $error("rail state wrong in normal mode");
    a_wait_off: assert property (wait_mode [*3] |-> !io_rail_enable && !processor_rail_enable)
        else $error("rails still on in wait mode");
    a_sleep_code: assert property (low_power_mode [*2] |-> processor_rail_code[2] == 1'b0)
        else $error("sleep code top bit set");
    c_low_power: cover property (low_power_mode);
    c_wait: cover property (wait_mode);
endmodule

// file: tb/test_pmic_lamp_and_converter_control.sv
// Self-checking bench for the lamp and converter configuration bank.
// Assumes the design and its checker are compiled first; 200 MHz clock.
module test_pmic_lamp_and_converter_control;
    timeunit 1ns;
    timeprecision 100ps;

    // ****************************************
    // Signals
    // ****************************************
    logic clk = 1'b0;
    logic rst = 1'b1;
    logic [7:0] reg_addr = 8'h00;
    logic [7:0] reg_wdata = 8'h00;
    logic reg_wr = 1'b0;
    logic reg_rd = 1'b0;
    logic io_strap = 1'b1;
    logic proc_strap = 1'b1;
    logic sleep_pin = 1'b0;
    logic wall_v = 1'b0;
    logic usb_v = 1'b0;
    logic lamp_req = 1'b0;
    wire [7:0] reg_rdata;
    wire reg_rvalid, cf_wall, cf_usb, sl_out, sl_oe, al_out, al_oe, ffq, lpm, wm;
    wire io_en, io_dis, pr_en, pr_dis, motor;
    wire [1:0] uvt, io_code;
    wire [2:0] pr_code;
    int fails = 0;
    int checks_done = 0;
    int i;
    logic [15:0] n1, n2;
    logic [7:0] rows [10][3] = '{'{8'h07, 8'hFF, 8'h03}, '{8'h07, 8'hFE, 8'h02}, '{8'h08, 8'h55, 8'h55},
        '{8'h09, 8'hAA, 8'hAA}, '{8'h0A, 8'h7F, 8'h7F}, '{8'h0B, 8'h80, 8'h80}, '{8'h0C, 8'hA5, 8'hA5},
        '{8'h0D, 8'h5A, 8'h5A}, '{8'h0E, 8'hFF, 8'h00}, '{8'h00, 8'hFF, 8'h00}};
    // Processor config, io config, {lpm, wm, io_en, io_dis, pr_en, pr_dis, code}
    logic [9:0] sleeps [5][3] = '{'{8'hD5, 8'h3E, 10'h291}, '{8'h55, 8'h3E, 10'h2A1},
        '{8'hD5, 8'h2E, 10'h155}, '{8'hD4, 8'h2A, 10'h105}, '{8'hD5, 8'h36, 10'h0A5}};

    pmic_lamp_and_converter_control #(.TIME_BASE_CYCLES(4)) dut
    (
        .clk(clk), .rst(rst), .reg_addr(reg_addr), .reg_wr(reg_wr), .reg_wdata(reg_wdata), .reg_rd(reg_rd),
        .reg_rdata(reg_rdata), .reg_rvalid(reg_rvalid), .io_rail_strap_pin(io_strap),
        .processor_rail_strap_pin(proc_strap), .sleep_request_pin(sleep_pin), .wall_input_valid(wall_v),
        .usb_input_valid(usb_v), .charger_lamp_request(lamp_req), .charge_from_wall(cf_wall),
        .charge_from_usb(cf_usb), .status_lamp_pin_in(!sl_oe), .status_lamp_pin_out(sl_out),
        .status_lamp_pin_oe(sl_oe), .aux_lamp_pin_in(!al_oe), .aux_lamp_pin_out(al_out),
        .aux_lamp_pin_oe(al_oe), .forced_fixed_freq(ffq), .undervoltage_threshold(uvt), .low_power_mode(lpm),
        .wait_mode(wm), .io_rail_enable(io_en), .io_rail_discharge(io_dis), .io_rail_code(io_code),
        .processor_rail_enable(pr_en), .processor_rail_discharge(pr_dis), .processor_rail_code(pr_code),
        .motor_driver_enable(motor)
    );

    // ****************************************
    // Tasks
    // ****************************************
    task automatic tick;
        @(posedge clk);
        #1;
    endtask
    task automatic chk(input string name, input logic [15:0] seen, input logic [15:0] exp);
        checks_done++;
        if (seen !== exp)
        begin
            fails++;
            $display("mismatch %s expected %h seen %h", name, exp, seen);
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        tick;
        reg_addr = a;
        reg_wdata = d;
        reg_wr = 1'b1;
        tick;
        reg_wr = 1'b0;
    endtask
    task automatic rd(input logic [7:0] a, input logic [7:0] exp);
        tick;
        reg_addr = a;
        reg_rd = 1'b1;
        tick;
        reg_rd = 1'b0;
        chk("rdata", reg_rdata, exp);
    endtask
    task automatic do_reset(input logic s);
        logic [7:0] exp [7];
        exp = '{8'h03, 8'h00, 8'h00, 8'h00, 8'h00, {7'h19, s}, {3'h3, s, 4'h0}};
        io_strap = s;
        proc_strap = s;
        rst = 1'b1;
        repeat (16) tick;
        rst = 1'b0;
        repeat (6) tick;
        chk("reset outs", {uvt, io_code, pr_code, io_en, pr_en}, {2'b01, 1'b1, s, 2'b11, s, 2'b11});
        for (int k = 0; k < 7; k++)
            rd(8'(8'h07 + k), exp[k]);
        $display("test reset with strap %0d done", s);
    endtask
    task automatic print_verdict;
        $display("checks %0d mismatches %0d", checks_done, fails);
        if (fails == 0 && checks_done > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask

    // ****************************************
    // Clock, watchdog and main sequence
    // ****************************************
    initial
    begin
        forever #2.5 clk = ~clk;
    end
    initial
    begin
        repeat (60000) @(posedge clk);
        fails++;
        $display("timeout");
        print_verdict;
    end
    initial
    begin
        do_reset(1'b1);
        for (i = 0; i < 10; i++)
        begin
            wr(rows[i][0], rows[i][1]);
            rd(rows[i][0], rows[i][2]);
        end
        $display("test registers done");
        for (i = 0; i < 16; i++)
        begin
            wr(8'h07, {6'h00, i[3:2]});
            wall_v = i[1];
            usb_v = i[0];
            repeat (3) tick;
            chk("wall path", cf_wall, i[2] & i[1]);
            chk("usb path", cf_usb, i[2] & i[3] & i[0] & !i[1]);
        end
        $display("test charger done");
        for (i = 0; i < 8; i++)
        begin
            wr(8'h0C, {i[0], i[1:0], 3'b000, i[1:0]});
            wr(8'h0D, {1'b0, i[2:0], 2'b00, i[0], 1'b0});
            repeat (2) tick;
            chk("io fields", {ffq, uvt, io_code}, {i[0], i[1:0], i[1:0]});
            chk("proc fields", {pr_code, motor}, {i[2:0], i[0]});
        end
        $display("test converter fields done");
        for (i = 0; i < 5; i++)
        begin
            wr(8'h0D, sleeps[i][0][7:0]);
            wr(8'h0C, sleeps[i][1][7:0]);
            sleep_pin = 1'b1;
            repeat (10) tick;
            chk("sleep", {lpm, wm, io_en, io_dis, pr_en, pr_dis, 1'b0, pr_code}, sleeps[i][2]);
            sleep_pin = 1'b0;
            repeat (10) tick;
            chk("wake", {lpm, wm, io_en, io_dis, pr_en, pr_dis, 1'b0, pr_code}, 10'h0A5);
        end
        $display("test sleep done");
        lamp_req = 1'b1;
        for (i = 0; i < 4; i++)
        begin
            wr(8'h08, {i[1], 7'h01});
            wr(8'h09, {i[0], 7'h00});
            wr(8'h0A, {i[1], 7'h02});
            wr(8'h0B, {i[0], 7'h01});
            repeat (4) tick;
            n1 = 0;
            n2 = 0;
            repeat (80)
            begin
                tick;
                n1 += sl_oe;
                n2 += al_oe;
            end
            chk("status lamp", n1, i == 1 ? 16 : i == 2 ? 0 : 80);
            chk("aux lamp", n2, i == 1 ? 12 : i == 3 ? 80 : 0);
        end
        wr(8'h08, 8'h00);
        wr(8'h09, 8'h00);
        lamp_req = 1'b0;
        repeat (3) tick;
        chk("charger lamp", sl_oe, 1'b0);
        $display("test lamps done");
        do_reset(1'b0);
        print_verdict;
    end
endmodule

bind pmic_lamp_and_converter_control pmic_lamp_and_converter_control_props u_props
(
    .clk(clk), .rst(rst), .reg_rd(reg_rd), .reg_rvalid(reg_rvalid), .sleep_request_pin(sleep_request_pin),
    .wall_input_valid(wall_input_valid), .usb_input_valid(usb_input_valid), .charge_from_wall(charge_from_wall),
    .charge_from_usb(charge_from_usb), .status_lamp_pin_out(status_lamp_pin_out),
    .aux_lamp_pin_out(aux_lamp_pin_out), .low_power_mode(low_power_mode), .wait_mode(wait_mode),
    .io_rail_enable(io_rail_enable), .io_rail_discharge(io_rail_discharge),
    .processor_rail_enable(processor_rail_enable), .processor_rail_discharge(processor_rail_discharge),
    .processor_rail_code(processor_rail_code)
);
